// ### design/cie_pkg.sv
package cie_pkg;

  // Datapath widths of the core.
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 7;
  localparam int PC_W     = 13;
  localparam int LIT_W    = 11;
  localparam int LATCH_W  = 8;
  localparam int MEM_DEPTH = 128;

  // Upper program counter bits come from this slice of the latch register.
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;

  // Constant operands of the arithmetic.
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;
  localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;
  localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
  localparam logic              DEST_W    = 1'h0;
  localparam logic              DEST_F    = 1'h1;

  // Operations decoded by the execute stage.
  typedef enum logic [2:0] {
    nop_op,
    clear_file_op,
    clear_working_op,
    decrement_op,
    decrement_skip_zero_op,
    increment_skip_zero_op,
    branch_op,
    or_literal_op
  } cie_op_t;

  // Execute stage phases.
  typedef enum logic [1:0] {
    ph_idle,
    ph_exec,
    ph_flush
  } cie_phase_t;

  // One instruction as presented by the fetch side.
  typedef struct packed {
    cie_op_t            op;
    logic               dest;
    logic [ADDR_W-1:0]  addr;
    logic [LIT_W-1:0]   lit;
  } cie_instr_t;

  // File register write seen from outside.
  typedef struct packed {
    logic               valid;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } cie_wr_t;

  // Whole state of the execute stage.
  typedef struct packed {
    cie_phase_t         phase;
    logic               ready;
    logic               skip;
    cie_instr_t         cur;
    logic [DATA_W-1:0]  w;
    logic               zero;
    logic [PC_W-1:0]    pc;
    logic               done;
    logic               nop;
    cie_wr_t            wr;
  } cie_state_t;

endpackage

// ### design/cie_dmem.sv
`timescale 1ns/1ns
module cie_dmem
  import cie_pkg::*;
#(
  parameter int AW    = ADDR_W,
  parameter int DW    = DATA_W,
  parameter int DEPTH = MEM_DEPTH
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  // The array has no reset; read data leaves through a register one cycle later.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ### design/cie_exec.sv
`timescale 1ns/1ns
module cie_exec
  import cie_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               in_valid,
  input  wire cie_instr_t         in_instr,
  input  wire logic [LATCH_W-1:0] program_counter_latch,
  output logic                    in_ready,
  output logic [DATA_W-1:0]       w_reg,
  output logic                    zero_flag,
  output logic [PC_W-1:0]         pc,
  output logic                    done,
  output logic                    nop_done,
  output logic                    skip_pending,
  output cie_wr_t                 file_wr
);

  cie_state_t        s;
  cie_state_t        next_s;
  logic              accept;
  logic              mem_we;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] result;

  // Operations that address a file register and take an execute phase.
  function automatic logic uses_file(input cie_op_t op);
    return (op == clear_file_op) || (op == decrement_op) ||
           (op == decrement_skip_zero_op) || (op == increment_skip_zero_op);
  endfunction

  assign accept = in_valid && s.ready;

  // Read is issued on acceptance so the data is ready in the execute phase.
  cie_dmem #(
    .AW    (ADDR_W),
    .DW    (DATA_W),
    .DEPTH (MEM_DEPTH)
  ) u_dmem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (s.cur.addr),
    .wdata (result),
    .raddr (in_instr.addr),
    .rdata (mem_rdata)
  );

  // Result of the file operation held in the current instruction.
  always_comb begin
    case (s.cur.op)
      clear_file_op:          result = ZERO_BYTE;
      decrement_op:           result = mem_rdata - ONE_BYTE;
      decrement_skip_zero_op: result = mem_rdata - ONE_BYTE;
      increment_skip_zero_op: result = mem_rdata + ONE_BYTE;
      default:                result = ZERO_BYTE;
    endcase
  end

  // Clear-file always writes the file; the others follow the selector.
  assign mem_we = (s.phase == ph_exec) &&
                  ((s.cur.op == clear_file_op) || (s.cur.dest == DEST_F));

  // Next state of the execute stage.
  always_comb begin
    next_s          = s;
    next_s.done     = 1'b0;
    next_s.nop      = 1'b0;
    next_s.wr.valid = 1'b0;
    case (s.phase)
      ph_idle: begin
        if (accept) begin
          next_s.pc  = s.pc + PC_ONE;
          next_s.cur = in_instr;
          if (s.skip) begin
            // The fetched instruction is dropped and a no-op retires instead.
            next_s.skip = 1'b0;
            next_s.nop  = 1'b1;
          end else if (uses_file(in_instr.op)) begin
            next_s.phase = ph_exec;
            next_s.ready = 1'b0;
          end else begin
            case (in_instr.op)
              clear_working_op: begin
                next_s.w    = ZERO_BYTE;
                next_s.zero = 1'b1;
                next_s.done = 1'b1;
              end
              or_literal_op: begin
                next_s.w    = s.w | in_instr.lit[DATA_W-1:0];
                next_s.zero = ((s.w | in_instr.lit[DATA_W-1:0]) == ZERO_BYTE);
                next_s.done = 1'b1;
              end
              branch_op: begin
                // Flags stay untouched; the second cycle stalls the fetch side.
                next_s.pc    = {program_counter_latch[LATCH_HI:LATCH_LO], in_instr.lit};
                next_s.phase = ph_flush;
                next_s.ready = 1'b0;
              end
              default: begin
                next_s.done = 1'b1;
              end
            endcase
          end
        end
      end
      ph_exec: begin
        next_s.phase = ph_idle;
        next_s.ready = 1'b1;
        next_s.done  = 1'b1;
        if (mem_we) begin
          next_s.wr.valid = 1'b1;
          next_s.wr.addr  = s.cur.addr;
          next_s.wr.data  = result;
        end else if (s.cur.op != clear_file_op) begin
          next_s.w = result;
        end
        case (s.cur.op)
          clear_file_op: next_s.zero = 1'b1;
          decrement_op:  next_s.zero = (result == ZERO_BYTE);
          decrement_skip_zero_op,
          increment_skip_zero_op: next_s.skip = (result == ZERO_BYTE);
          default: next_s.zero = s.zero;
        endcase
      end
      ph_flush: begin
        next_s.phase = ph_idle;
        next_s.ready = 1'b1;
        next_s.done  = 1'b1;
      end
      default: begin
        next_s.phase = ph_idle;
        next_s.ready = 1'b1;
      end
    endcase
  end

  // State register; every output is a field of it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.phase <= ph_idle;
      s.ready <= 1'b1;
      s.pc    <= PC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready     = s.ready;
  assign w_reg        = s.w;
  assign zero_flag    = s.zero;
  assign pc           = s.pc;
  assign done         = s.done;
  assign nop_done     = s.nop;
  assign skip_pending = s.skip;
  assign file_wr      = s.wr;

  clear_file_a: assert property (@(posedge clk) disable iff (!rstn)
    (s.phase == ph_exec && s.cur.op == clear_file_op) |=>
      (zero_flag && file_wr.valid && file_wr.data == ZERO_BYTE))
    else $error("clear file did not write zero and set zero flag");

  clear_working_a: assert property (@(posedge clk) disable iff (!rstn)
    (accept && !s.skip && in_instr.op == clear_working_op) |=>
      (w_reg == ZERO_BYTE && zero_flag && done))
    else $error("clear working did not clear and set zero flag");

  decrement_dest_a: assert property (@(posedge clk) disable iff (!rstn)
    (s.phase == ph_exec && s.cur.op == decrement_op) |=>
      ((s.cur.dest ? (file_wr.valid && file_wr.data == $past(mem_rdata) - ONE_BYTE)
                   : (!file_wr.valid && w_reg == $past(mem_rdata) - ONE_BYTE)) &&
       zero_flag == ($past(mem_rdata) == ONE_BYTE)))
    else $error("decrement result or zero flag wrong");

  dec_skip_flags_a: assert property (@(posedge clk) disable iff (!rstn)
    (s.phase == ph_exec && s.cur.op == decrement_skip_zero_op) |=>
      ($stable(zero_flag) && skip_pending == ($past(mem_rdata) == ONE_BYTE)))
    else $error("decrement skip touched a flag or skipped wrongly");

  inc_skip_dest_a: assert property (@(posedge clk) disable iff (!rstn)
    (s.phase == ph_exec && s.cur.op == increment_skip_zero_op && s.cur.dest == DEST_W) |=>
      (w_reg == $past(mem_rdata) + ONE_BYTE && !file_wr.valid && $stable(zero_flag)))
    else $error("increment skip to working register wrong");

  skip_nop_a: assert property (@(posedge clk) disable iff (!rstn)
    (accept && s.skip) |=> (nop_done && !done && !skip_pending && $stable(w_reg)
                            && $stable(zero_flag) && in_ready))
    else $error("skipped instruction was not replaced by a no-op");

  branch_target_a: assert property (@(posedge clk) disable iff (!rstn)
    (accept && !s.skip && in_instr.op == branch_op) |=>
      (pc == {$past(program_counter_latch[LATCH_HI:LATCH_LO]), $past(in_instr.lit)}
       && $stable(zero_flag)))
    else $error("branch target wrong");

  branch_cycles_a: assert property (@(posedge clk) disable iff (!rstn)
    (accept && !s.skip && in_instr.op == branch_op) |=>
      (!in_ready && !done) ##1 (in_ready && done))
    else $error("branch did not take two cycles");

  or_literal_a: assert property (@(posedge clk) disable iff (!rstn)
    (accept && !s.skip && in_instr.op == or_literal_op) |=>
      (w_reg == ($past(w_reg) | $past(in_instr.lit[DATA_W-1:0])) &&
       zero_flag == (w_reg == ZERO_BYTE)))
    else $error("or literal result or zero flag wrong");

  file_addr_a: assert property (@(posedge clk) disable iff (!rstn)
    (accept && !s.skip && uses_file(in_instr.op)) |=>
      ##1 (file_wr.valid |-> file_wr.addr == $past(in_instr.addr, 2)))
    else $error("file write went to the wrong address");

endmodule

// ### sim/tb_core_instruction_execute_subset.sv
`timescale 1ns/1ns
// One comparison: counts it, and reports and counts a mismatch at once.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_core_instruction_execute_subset
  import cie_pkg::*;
();
  logic               clk;
  logic               rstn;
  logic               in_valid;
  logic               in_ready;
  logic               zero_flag;
  logic               done;
  logic               nop_done;
  logic               skip_pending;
  cie_instr_t         in_instr;
  logic [LATCH_W-1:0] latch;
  logic [DATA_W-1:0]  w_reg;
  logic [PC_W-1:0]    pc;
  cie_wr_t            file_wr;
  int                 failures;
  int                 n_tests;

  cie_exec DUT (
    .clk                   (clk),
    .rstn                  (rstn),
    .in_valid              (in_valid),
    .in_instr              (in_instr),
    .program_counter_latch (latch),
    .in_ready              (in_ready),
    .w_reg                 (w_reg),
    .zero_flag             (zero_flag),
    .pc                    (pc),
    .done                  (done),
    .nop_done              (nop_done),
    .skip_pending          (skip_pending),
    .file_wr               (file_wr)
  );

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Offers one instruction and returns on the edge that takes it.
  // Ready is read at the falling edge, so the taking edge is known without a race.
  task automatic issue(input cie_op_t op, input logic d, input logic [ADDR_W-1:0] a,
                       input logic [LIT_W-1:0] k);
    int i;
    i = 0;
    @(posedge clk);
    in_valid <= 1'h1;
    in_instr <= '{op, d, a, k};
    @(negedge clk);
    while (in_ready !== 1'h1 && i < 10) begin
      i++;
      @(negedge clk);
    end
    @(posedge clk);
    in_valid <= 1'h0;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Only the low byte of the immediate may reach the working register.
  task automatic t_literal();
    issue(clear_working_op, 1'h0, 7'h00, 11'h000);
    step(1);
    `CHK("w", 8'h00, w_reg)
    `CHK("z", 1'h1, zero_flag)
    issue(or_literal_op, 1'h0, 7'h00, 11'h75A);
    step(1);
    `CHK("w", 8'h5A, w_reg)
    `CHK("z", 1'h0, zero_flag)
    `CHK("done", 1'h1, done)
  endtask

  // Highest address, with the selector at 0, still writes the file.
  // A write word packs valid, address and data from the top bit down.
  task automatic t_clear_file();
    issue(clear_file_op, 1'h0, 7'h7F, 11'h000);
    step(2);
    `CHK("wr", 16'hFF00, file_wr)
    `CHK("z", 1'h1, zero_flag)
    `CHK("w", 8'h5A, w_reg)
  endtask

  task automatic t_decrement();
    issue(decrement_op, 1'h1, 7'h7F, 11'h000);
    step(2);
    `CHK("wr", 16'hFFFF, file_wr)
    `CHK("z", 1'h0, zero_flag)
    `CHK("w", 8'h5A, w_reg)
    issue(clear_file_op, 1'h1, 7'h10, 11'h000);
    step(2);
    issue(increment_skip_zero_op, 1'h1, 7'h10, 11'h000);
    step(2);
    `CHK("wr", 16'h9001, file_wr)
    `CHK("z", 1'h1, zero_flag)
    `CHK("skip", 1'h0, skip_pending)
    issue(decrement_op, 1'h0, 7'h7F, 11'h000);
    step(2);
    `CHK("w", 8'hFE, w_reg)
    `CHK("wr_v", 1'h0, file_wr.valid)
    `CHK("z", 1'h0, zero_flag)
    issue(decrement_op, 1'h0, 7'h10, 11'h000);
    step(2);
    `CHK("w", 8'h00, w_reg)
    `CHK("z", 1'h1, zero_flag)
  endtask

  // Zero flag is cleared first so a flag written from the zero result would show.
  task automatic t_skip();
    issue(or_literal_op, 1'h0, 7'h00, 11'h001);
    step(1);
    issue(increment_skip_zero_op, 1'h0, 7'h7F, 11'h000);
    step(2);
    `CHK("w", 8'h00, w_reg)
    `CHK("z", 1'h0, zero_flag)
    `CHK("skip", 1'h1, skip_pending)
    issue(or_literal_op, 1'h0, 7'h00, 11'h0F0);
    step(1);
    `CHK("nop", 1'h1, nop_done)
    `CHK("done", 1'h0, done)
    `CHK("w", 8'h00, w_reg)
    `CHK("skip", 1'h0, skip_pending)
    issue(decrement_skip_zero_op, 1'h1, 7'h10, 11'h000);
    step(2);
    `CHK("wr", 16'h9000, file_wr)
    `CHK("z", 1'h0, zero_flag)
    `CHK("skip", 1'h1, skip_pending)
    issue(clear_working_op, 1'h0, 7'h00, 11'h000);
    step(1);
    `CHK("nop", 1'h1, nop_done)
    `CHK("z", 1'h0, zero_flag)
    issue(decrement_skip_zero_op, 1'h0, 7'h7F, 11'h000);
    step(2);
    `CHK("w", 8'hFE, w_reg)
    `CHK("skip", 1'h0, skip_pending)
  endtask

  // Other latch bits are set to show that only bits 4:3 reach the counter.
  task automatic t_branch(input logic [LATCH_W-1:0] lat, input logic [LIT_W-1:0] k,
                          input logic [PC_W-1:0] exp_pc);
    @(posedge clk);
    latch <= lat;
    issue(branch_op, 1'h0, 7'h00, k);
    step(1);
    `CHK("pc", exp_pc, pc)
    `CHK("rdy", 1'h0, in_ready)
    `CHK("done", 1'h0, done)
    step(1);
    `CHK("done", 1'h1, done)
    `CHK("z", 1'h0, zero_flag)
    issue(nop_op, 1'h0, 7'h00, 11'h000);
    step(1);
    `CHK("pc", exp_pc + PC_ONE, pc)
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    rstn = 1'h0;
    in_valid = 1'h0;
    in_instr = '0;
    latch = '0;
    failures = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    t_literal();
    t_clear_file();
    t_decrement();
    t_skip();
    t_branch(8'hF7, 11'h7FF, 13'h17FF);
    t_branch(8'h08, 11'h000, 13'h0800);
    test_done();
  end
endmodule
